// file: logic/clk_sel_pkg.sv
// Constants and types for the system clock source selector
package clk_sel_pkg;

  // Clock rate of the register side
  localparam int CLK_MHZ = 10;

  // Register byte addresses
  localparam logic [7:0] ADDR_SOURCE = 8'h00;
  localparam logic [7:0] ADDR_XTAL = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Source register fields
  localparam int DIV_LSB = 5;
  localparam int HIGH_SEL_BIT = 3;
  localparam int LOW_SEL_BIT = 2;

  // Slow crystal register fields
  localparam int XT_EN_BIT = 0;
  localparam int XT_READY_BIT = 1;
  localparam int XT_SPEEDUP_BIT = 2;

  // Control register fields
  localparam int FAST_EN_BIT = 0;
  localparam int HALT_BIT = 1;
  localparam int PIN_OSC_BIT = 2;

  // Status register fields
  localparam int LOCKED_BIT = 0;
  localparam int SWITCHING_BIT = 1;
  localparam int HALTED_BIT = 2;

  // Reset values
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic HIGH_SEL_RST = 1'b0;
  localparam logic LOW_SEL_RST = 1'b0;
  localparam logic XT_EN_RST = 1'b0;
  localparam logic SPEEDUP_RST = 1'b0;
  localparam logic FAST_EN_RST = 1'b1;
  localparam logic HALT_RST = 1'b0;
  localparam logic PIN_OSC_RST = 1'b0;

  // Divider code that selects the sub clock
  localparam logic [2:0] DIV_SUB = 3'h7;
  // Divider code for the undivided high-speed clock
  localparam logic [2:0] DIV_ONE = 3'h0;

  // Oscillator index in the sampled input vector
  localparam int OSC_FAST_RC = 0;
  localparam int OSC_FAST_XTAL = 1;
  localparam int OSC_SLOW_RC = 2;
  localparam int OSC_SLOW_XTAL = 3;
  localparam int OSC_COUNT = 4;

  // Crystal start-up times in microseconds
  localparam int XT_SPEEDUP_START_US = 1000;
  localparam int XT_LOWPWR_START_US = 3000;
  // Start-up counts in clock cycles
  localparam int XT_SPEEDUP_START_CYC = XT_SPEEDUP_START_US * CLK_MHZ;
  localparam int XT_LOWPWR_START_CYC = XT_LOWPWR_START_US * CLK_MHZ;

  // Output switch states
  typedef enum logic [0:0] {
    SW_RUN,
    SW_PARK
  } switch_state_t;

endpackage

// file: logic/slow_crystal_if.sv
// Interface between the selector and the slow crystal controller
`timescale 1ns/1ps
`default_nettype none
interface slow_crystal_if;
  logic enable;        // Software crystal enable
  logic pin_osc;       // Pins given to the oscillator
  logic locked;        // Crystal is the system clock
  logic speedup_wr;    // Write pulse for speed-up bit
  logic speedup_wdata; // Written speed-up value
  logic speedup;       // Held speed-up mode
  logic ready;         // Start-up wait is over

  // Selector side
  modport host (
    output enable, pin_osc, locked, speedup_wr, speedup_wdata,
    input speedup, ready
  );

  // Controller side
  modport ctrl (
    input enable, pin_osc, locked, speedup_wr, speedup_wdata,
    output speedup, ready
  );
endinterface
`default_nettype wire

// file: logic/slow_crystal_ctrl.sv
// Slow crystal mode bit and start-up timer
`timescale 1ns/1ps
`default_nettype none
module slow_crystal_ctrl #(
  parameter int SPEEDUP_START_CYC = clk_sel_pkg::XT_SPEEDUP_START_CYC,
  parameter int LOWPWR_START_CYC = clk_sel_pkg::XT_LOWPWR_START_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Selector link
  slow_crystal_if.ctrl xt
);

  logic speedup_q, speedup_d;     // Held mode bit
  logic ready_q, ready_d;         // Start-up finished
  logic [15:0] cnt_q, cnt_d;      // Start-up counter
  logic [15:0] target;            // Cycles for current mode

  // Low power mode waits longer than speed-up mode
  assign target = xt.speedup ? 16'(SPEEDUP_START_CYC - 1)
                             : 16'(LOWPWR_START_CYC - 1);

  // Next mode bit and start-up progress
  always_comb begin
    speedup_d = speedup_q;
    ready_d = ready_q;
    cnt_d = cnt_q;
    // Mode changes only while crystal is not driving the system
    if (xt.speedup_wr && !xt.locked) begin
      speedup_d = xt.speedup_wdata;
    end
    if (!xt.enable || !xt.pin_osc) begin
      // Stopped oscillator restarts its wait
      ready_d = 1'b0;
      cnt_d = 16'h0000;
    end else if (!ready_q) begin
      // Count start-up after the enable is set
      if (cnt_q >= target) begin
        ready_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
    // Once ready, a mode change keeps the clock running
  end

  // Register the controller state
  always_ff @(posedge clk) begin
    if (reset) begin
      speedup_q <= clk_sel_pkg::SPEEDUP_RST;
      ready_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      speedup_q <= speedup_d;
      ready_q <= ready_d;
      cnt_q <= cnt_d;
    end
  end

  assign xt.speedup = speedup_q;
  assign xt.ready = ready_q;

endmodule
`default_nettype wire

// file: logic/clk_source_selector.sv
// System clock source selector with APB control registers
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module clk_source_selector #(
  parameter int SPEEDUP_START_CYC = clk_sel_pkg::XT_SPEEDUP_START_CYC,
  parameter int LOWPWR_START_CYC = clk_sel_pkg::XT_LOWPWR_START_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator outputs
  input wire logic fast_rc_osc,
  input wire logic fast_crystal_osc,
  input wire logic slow_rc_osc,
  input wire logic slow_crystal_osc,
  // Oscillator controls
  output logic fast_rc_osc_en,
  output logic fast_crystal_osc_en,
  output logic slow_crystal_osc_en,
  output logic slow_crystal_speedup,
  output logic slow_crystal_pins_osc,
  // Generated clocks
  output logic system_clock,
  output logic timer_clock
);

  // Crystal controller link
  slow_crystal_if xt ();

  // Raw oscillator levels as a vector
  logic [clk_sel_pkg::OSC_COUNT-1:0] osc_raw;
  // First synchroniser stage
  logic [clk_sel_pkg::OSC_COUNT-1:0] osc_s1_q;
  // Second synchroniser stage
  logic [clk_sel_pkg::OSC_COUNT-1:0] osc_s2_q;
  // Previous level for edge detect
  logic [clk_sel_pkg::OSC_COUNT-1:0] osc_prev_q;
  // One-cycle rising edge markers
  logic [clk_sel_pkg::OSC_COUNT-1:0] osc_rise;

  assign osc_raw[clk_sel_pkg::OSC_FAST_RC] = fast_rc_osc;
  assign osc_raw[clk_sel_pkg::OSC_FAST_XTAL] = fast_crystal_osc;
  assign osc_raw[clk_sel_pkg::OSC_SLOW_RC] = slow_rc_osc;
  assign osc_raw[clk_sel_pkg::OSC_SLOW_XTAL] = slow_crystal_osc;

  // Two-stage sampling and edge detect per oscillator
  genvar gi;
  generate
    for (gi = 0; gi < clk_sel_pkg::OSC_COUNT; gi++) begin : g_osc
      always_ff @(posedge clk) begin
        if (reset) begin
          osc_s1_q[gi] <= 1'b0;
          osc_s2_q[gi] <= 1'b0;
          osc_prev_q[gi] <= 1'b0;
        end else begin
          osc_s1_q[gi] <= osc_raw[gi];
          osc_s2_q[gi] <= osc_s1_q[gi];
          osc_prev_q[gi] <= osc_s2_q[gi];
        end
      end
      // Edge seen only on the second stage
      assign osc_rise[gi] = osc_s2_q[gi] & ~osc_prev_q[gi];
    end
  endgenerate

  // Software-visible control fields
  logic [2:0] div_reg_q, div_reg_d;     // Divider select
  logic high_reg_q, high_reg_d;         // High source select
  logic low_reg_q, low_reg_d;           // Low source select
  logic xt_en_q, xt_en_d;               // Slow crystal enable
  logic fast_en_q, fast_en_d;           // Fast osc keep-running
  logic halt_q, halt_d;                 // System clock halt
  logic pin_q, pin_d;                   // Crystal pin function
  // APB answer registers
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  // Bus decode helpers
  logic wr_en;                          // Write takes effect now
  logic [31:0] rd_word;                 // Word at current address
  logic rd_hit;                         // Address is mapped

  // Active selection used by the output path
  logic [2:0] act_div_q, act_div_d;
  logic act_high_q, act_high_d;
  logic act_low_q, act_low_d;
  // Divider counter and divided level
  logic [4:0] div_cnt_q, div_cnt_d;
  logic div_lvl_q, div_lvl_d;
  // Output switch state and output levels
  clk_sel_pkg::switch_state_t sw_q, sw_d;
  logic sys_clk_q, sys_clk_d;
  logic timer_clk_q, timer_clk_d;
  // Oscillator control outputs
  logic fast_rc_osc_en_q, fast_rc_osc_en_d;
  logic hxt_en_q, hxt_en_d;
  logic lxt_en_q, lxt_en_d;

  // Selected clock levels and edges
  logic high_lvl;           // High-speed clock level
  logic high_rise;          // High-speed clock rising edge
  logic sub_lvl;            // Sub clock level
  logic cand_lvl;           // Level the output would follow
  logic [4:0] half_last;    // Last count of a half period
  logic need_high;          // High-speed clock is in use
  logic sel_change;         // Software asks for a new selection
  logic locked;             // Crystal is the system clock

  // Crystal drives the system when sub clock and crystal chosen
  assign locked = (div_reg_q == clk_sel_pkg::DIV_SUB) && low_reg_q;

  // Fast crystal or fast RC gives the high-speed clock
  assign high_lvl = act_high_q ? osc_s2_q[clk_sel_pkg::OSC_FAST_XTAL]
                               : osc_s2_q[clk_sel_pkg::OSC_FAST_RC];
  assign high_rise = act_high_q ? osc_rise[clk_sel_pkg::OSC_FAST_XTAL]
                                : osc_rise[clk_sel_pkg::OSC_FAST_RC];

  // Slow crystal, once started, or slow RC gives the sub clock
  always_comb begin
    if (act_low_q) begin
      sub_lvl = osc_s2_q[clk_sel_pkg::OSC_SLOW_XTAL] & xt.ready;
    end else begin
      sub_lvl = osc_s2_q[clk_sel_pkg::OSC_SLOW_RC];
    end
  end

  // Half period in high-speed edges for ratios 2 to 64
  always_comb begin
    half_last = 5'h00;
    if (act_div_q != clk_sel_pkg::DIV_ONE && act_div_q != clk_sel_pkg::DIV_SUB) begin
      half_last = 5'((6'h01 << (act_div_q - 3'h1)) - 6'h01);
    end
  end

  // Level the output follows for the active choice
  always_comb begin
    if (act_div_q == clk_sel_pkg::DIV_SUB) begin
      cand_lvl = sub_lvl;
    end else if (act_div_q == clk_sel_pkg::DIV_ONE) begin
      cand_lvl = high_lvl;
    end else begin
      cand_lvl = div_lvl_q;
    end
  end

  // Pending change of source, ratio or halt
  assign sel_change = (div_reg_q != act_div_q) || (high_reg_q != act_high_q) ||
                      (low_reg_q != act_low_q) || halt_q;

  // High-speed clock needed now or by the pending choice
  assign need_high = (act_div_q != clk_sel_pkg::DIV_SUB) ||
                     (div_reg_q != clk_sel_pkg::DIV_SUB);

  // Output path next state
  always_comb begin
    sw_d = sw_q;
    act_div_d = act_div_q;
    act_high_d = act_high_q;
    act_low_d = act_low_q;
    div_cnt_d = div_cnt_q;
    div_lvl_d = div_lvl_q;
    sys_clk_d = sys_clk_q;
    // Divider runs on high-speed edges
    if (high_rise) begin
      if (div_cnt_q >= half_last) begin
        div_cnt_d = 5'h00;
        div_lvl_d = ~div_lvl_q;
      end else begin
        div_cnt_d = div_cnt_q + 5'h01;
      end
    end
    unique case (sw_q)
      clk_sel_pkg::SW_RUN: begin
        // Leave only while output is low, so no pulse is cut
        if (sel_change && !sys_clk_q) begin
          sw_d = clk_sel_pkg::SW_PARK;
          sys_clk_d = 1'b0;
        end else begin
          sys_clk_d = cand_lvl;
        end
      end
      clk_sel_pkg::SW_PARK: begin
        // Output held low while the new choice settles
        sys_clk_d = 1'b0;
        act_div_d = div_reg_q;
        act_high_d = high_reg_q;
        act_low_d = low_reg_q;
        if (sel_change) begin
          // Restart the divider for the new ratio
          div_cnt_d = 5'h00;
          div_lvl_d = 1'b0;
        end else if (!cand_lvl) begin
          // Resume when the new source is low as well
          sw_d = clk_sel_pkg::SW_RUN;
        end
      end
    endcase
    // Timer clock keeps running from the slow RC in halt
    timer_clk_d = osc_s2_q[clk_sel_pkg::OSC_SLOW_RC];
  end

  // Oscillator enables
  always_comb begin
    // Fast oscillator stops in sub mode unless kept on
    fast_rc_osc_en_d = (fast_en_q || need_high) &&
                (!high_reg_q || !act_high_q);
    hxt_en_d = (fast_en_q || need_high) &&
               (high_reg_q || act_high_q);
    // Crystal runs only when enabled and pins are given to it
    // Built from the next values so the enable never outlives the pins
    lxt_en_d = xt_en_d && pin_d;
  end

  // Write strobe on the access edge that completes
  assign wr_en = psel && penable && pready_q && pwrite;

  // Read word decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      clk_sel_pkg::ADDR_SOURCE: begin
        rd_word[clk_sel_pkg::DIV_LSB +: 3] = div_reg_q;
        rd_word[clk_sel_pkg::HIGH_SEL_BIT] = high_reg_q;
        rd_word[clk_sel_pkg::LOW_SEL_BIT] = low_reg_q;
      end
      clk_sel_pkg::ADDR_XTAL: begin
        rd_word[clk_sel_pkg::XT_EN_BIT] = xt_en_q;
        rd_word[clk_sel_pkg::XT_READY_BIT] = xt.ready;
        rd_word[clk_sel_pkg::XT_SPEEDUP_BIT] = xt.speedup;
      end
      clk_sel_pkg::ADDR_CTRL: begin
        rd_word[clk_sel_pkg::FAST_EN_BIT] = fast_en_q;
        rd_word[clk_sel_pkg::HALT_BIT] = halt_q;
        rd_word[clk_sel_pkg::PIN_OSC_BIT] = pin_q;
      end
      clk_sel_pkg::ADDR_STATUS: begin
        rd_word[clk_sel_pkg::LOCKED_BIT] = locked;
        rd_word[clk_sel_pkg::SWITCHING_BIT] = (sw_q == clk_sel_pkg::SW_PARK);
        rd_word[clk_sel_pkg::HALTED_BIT] = (sw_q == clk_sel_pkg::SW_PARK) && halt_q;
      end
      default: begin
        // Unmapped address answers with an error
        rd_hit = 1'b0;
      end
    endcase
  end

  // Register file and APB answer next state
  always_comb begin
    div_reg_d = div_reg_q;
    high_reg_d = high_reg_q;
    low_reg_d = low_reg_q;
    xt_en_d = xt_en_q;
    fast_en_d = fast_en_q;
    halt_d = halt_q;
    pin_d = pin_q;
    // Answer is prepared in the setup cycle
    pready_d = psel && !penable;
    pslverr_d = psel && !penable && !rd_hit;
    prdata_d = (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
    if (wr_en) begin
      unique case (paddr)
        clk_sel_pkg::ADDR_SOURCE: begin
          div_reg_d = pwdata[clk_sel_pkg::DIV_LSB +: 3];
          high_reg_d = pwdata[clk_sel_pkg::HIGH_SEL_BIT];
          low_reg_d = pwdata[clk_sel_pkg::LOW_SEL_BIT];
        end
        clk_sel_pkg::ADDR_XTAL: begin
          xt_en_d = pwdata[clk_sel_pkg::XT_EN_BIT];
        end
        clk_sel_pkg::ADDR_CTRL: begin
          fast_en_d = pwdata[clk_sel_pkg::FAST_EN_BIT];
          halt_d = pwdata[clk_sel_pkg::HALT_BIT];
          pin_d = pwdata[clk_sel_pkg::PIN_OSC_BIT];
        end
        default: begin
          // Status and unmapped writes change nothing
        end
      endcase
    end
  end

  // Speed-up write passes to the crystal controller
  assign xt.speedup_wr = wr_en && (paddr == clk_sel_pkg::ADDR_XTAL);
  assign xt.speedup_wdata = pwdata[clk_sel_pkg::XT_SPEEDUP_BIT];
  assign xt.enable = xt_en_q;
  assign xt.pin_osc = pin_q;
  assign xt.locked = locked;

  // Register the control fields and bus answer
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg_q <= clk_sel_pkg::DIV_RST;
      high_reg_q <= clk_sel_pkg::HIGH_SEL_RST;
      low_reg_q <= clk_sel_pkg::LOW_SEL_RST;
      xt_en_q <= clk_sel_pkg::XT_EN_RST;
      fast_en_q <= clk_sel_pkg::FAST_EN_RST;
      halt_q <= clk_sel_pkg::HALT_RST;
      pin_q <= clk_sel_pkg::PIN_OSC_RST;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      div_reg_q <= div_reg_d;
      high_reg_q <= high_reg_d;
      low_reg_q <= low_reg_d;
      xt_en_q <= xt_en_d;
      fast_en_q <= fast_en_d;
      halt_q <= halt_d;
      pin_q <= pin_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Register the output path and oscillator controls
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_q <= clk_sel_pkg::SW_PARK;
      act_div_q <= clk_sel_pkg::DIV_RST;
      act_high_q <= clk_sel_pkg::HIGH_SEL_RST;
      act_low_q <= clk_sel_pkg::LOW_SEL_RST;
      div_cnt_q <= 5'h00;
      div_lvl_q <= 1'b0;
      sys_clk_q <= 1'b0;
      timer_clk_q <= 1'b0;
      fast_rc_osc_en_q <= 1'b0;
      hxt_en_q <= 1'b0;
      lxt_en_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
      act_div_q <= act_div_d;
      act_high_q <= act_high_d;
      act_low_q <= act_low_d;
      div_cnt_q <= div_cnt_d;
      div_lvl_q <= div_lvl_d;
      sys_clk_q <= sys_clk_d;
      timer_clk_q <= timer_clk_d;
      fast_rc_osc_en_q <= fast_rc_osc_en_d;
      hxt_en_q <= hxt_en_d;
      lxt_en_q <= lxt_en_d;
    end
  end

  // Slow crystal mode and start-up timer
  slow_crystal_ctrl #(
    .SPEEDUP_START_CYC(SPEEDUP_START_CYC),
    .LOWPWR_START_CYC(LOWPWR_START_CYC)
  ) u_xtal (
    .clk(clk),
    .reset(reset),
    .xt(xt)
  );

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fast_rc_osc_en = fast_rc_osc_en_q;
  assign fast_crystal_osc_en = hxt_en_q;
  assign slow_crystal_osc_en = lxt_en_q;
  assign slow_crystal_speedup = xt.speedup;
  assign slow_crystal_pins_osc = pin_q;
  assign system_clock = sys_clk_q;
  assign timer_clock = timer_clk_q;

endmodule
`default_nettype wire

// file: testbench/clk_sel_assertions.sv
// Concurrent checks on the clock source selector ports
`timescale 1ns/1ps
`default_nettype none
module clk_sel_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Crystal controls and clocks
  input wire logic slow_crystal_osc_en,
  input wire logic slow_crystal_speedup,
  input wire logic slow_crystal_pins_osc,
  input wire logic system_clock
);
  logic wr_ev; // Completed write transfer
  logic lock_q, lock_d; // Written bits make the crystal the system clock
  logic sp_q, sp_d; // Expected speed-up mode
  logic halt_q, halt_d; // Written halt request
  logic [8:0] hcnt_q, hcnt_d; // Cycles spent halted, saturating

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Shadow the control bits from completed writes
  always_comb begin
    wr_ev = psel & penable & pready & pwrite;
    lock_d = lock_q;
    sp_d = sp_q;
    halt_d = halt_q;
    if (wr_ev && paddr == clk_sel_pkg::ADDR_SOURCE) begin
      lock_d = pwdata[7:5] == clk_sel_pkg::DIV_SUB && pwdata[clk_sel_pkg::LOW_SEL_BIT];
    end
    if (wr_ev && paddr == clk_sel_pkg::ADDR_XTAL && !lock_q) begin
      sp_d = pwdata[clk_sel_pkg::XT_SPEEDUP_BIT];
    end
    if (wr_ev && paddr == clk_sel_pkg::ADDR_CTRL) begin
      halt_d = pwdata[clk_sel_pkg::HALT_BIT];
    end
    hcnt_d = !halt_q ? 9'h000 : (hcnt_q == 9'h1FF ? hcnt_q : hcnt_q + 9'h001);
  end

  // Register the shadows
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_q <= 1'b0;
      sp_q <= 1'b0;
      halt_q <= 1'b0;
      hcnt_q <= 9'h000;
    end else begin
      lock_q <= lock_d;
      sp_q <= sp_d;
      halt_q <= halt_d;
      hcnt_q <= hcnt_d;
    end
  end

  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h0C |=> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (psel && !penable && paddr == 8'h04 |=> !pslverr)
    else $error("error on mapped address");
  a_pins_crystal: assert property (slow_crystal_osc_en |-> slow_crystal_pins_osc)
    else $error("crystal on without its pins");
  a_speedup_follow: assert property (wr_ev && paddr == 8'h04 |-> ##2 slow_crystal_speedup == sp_q)
    else $error("speed-up mode wrong after write");
  a_speedup_frozen: assert property (wr_ev && paddr == 8'h04 && lock_q |=> $stable(slow_crystal_speedup)[*3])
    else $error("speed-up changed while locked");
  a_no_runt_high: assert property ($fell(system_clock) |-> $past(system_clock, 2))
    else $error("short high pulse on system clock");
  a_no_runt_low: assert property ($rose(system_clock) |-> !$past(system_clock, 2))
    else $error("short low pulse on system clock");
  a_halt_parks: assert property (hcnt_q > 9'h190 |-> !system_clock)
    else $error("system clock runs while halted");
endmodule
bind clk_source_selector clk_sel_assertions u_chk (.clk, .reset, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .slow_crystal_osc_en, .slow_crystal_speedup,
  .slow_crystal_pins_osc, .system_clock);
`default_nettype wire

// file: testbench/test_clk_source_selector.sv
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
`default_nettype none
module test_clk_source_selector;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, e, tp; // Bus, clock, scratch
  logic [7:0] paddr; // Bus address
  logic [31:0] pwdata, prdata, rd_v; // Bus data, last read
  logic [3:0] osc; // Oscillator levels in package index order
  logic [6:0] en; // Oscillator controls and generated clocks
  int hp[4], oc[4], src, xtl, ctl, mismatches, compares, p, n1, n2; // Model state

  // Design with short crystal start-up counts
  clk_source_selector #(.SPEEDUP_START_CYC(8), .LOWPWR_START_CYC(16)) uut (.clk, .reset,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .fast_rc_osc(osc[0]), .fast_crystal_osc(osc[1]), .slow_rc_osc(osc[2]),
    .slow_crystal_osc(osc[3]), .fast_rc_osc_en(en[0]), .fast_crystal_osc_en(en[1]),
    .slow_crystal_osc_en(en[2]), .slow_crystal_speedup(en[3]),
    .slow_crystal_pins_osc(en[4]), .system_clock(en[5]), .timer_clock(en[6]));

  // Bus clock
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  // Oscillators toggle every hp cycles
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (oc[i] + 1 >= hp[i]) begin
        oc[i] <= 0;
        osc[i] <= ~osc[i];
      end else begin
        oc[i] <= oc[i] + 1;
      end
    end
  end

  // Compare one value
  task automatic chk(input logic [31:0] s, input logic [31:0] e0, input string m);
    compares++;
    if (s !== e0) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, m, s, e0);
    end
  endtask

  // One APB transfer, read data left in rd_v
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd_v = prdata;
    e = pslverr;
    chk(n, 1, "pready wait");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write with random bits 31 to 8, updating the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d | ($urandom() & 32'hFFFFFF00));
    if (a == 8'h00) src = d & 32'hEC;
    if (a == 8'h04) xtl = (src[7:5] == 3'h7 && src[2]) ? (xtl & 4) | (d & 1) : d & 5;
    if (a == 8'h08) ctl = d & 7;
  endtask

  // Read and compare masked bits
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    apb(1'b0, a, 32'h0);
    chk(rd_v & k, x & k, "read");
    chk(e, 0, "read error");
  endtask

  // Oscillator controls after things settle
  task automatic outs();
    logic fe;
    repeat (300) @(posedge clk);
    fe = src[7:5] != 3'h7 || ctl[0];
    chk(en[4:0], {ctl[2], xtl[2], xtl[0] & ctl[2], src[3] & fe, !src[3] & fe}, "ctl");
  endtask

  // Cycles between two rises of the system clock
  task automatic per();
    int t0;
    logic pv;
    t0 = -1;
    p = -1;
    pv = en[5];
    for (int n = 0; n < 2000 && p < 0; n++) begin
      @(posedge clk);
      if (en[5] === 1'b1 && pv === 1'b0) begin
        if (t0 >= 0) p = n - t0;
        t0 = n;
      end
      pv = en[5];
    end
  endtask

  // Count polls until the crystal reports ready
  task automatic poll(output int n);
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (rd_v[1] !== 1'b1 && n < 50);
    chk(rd_v[1], 1, "ready");
  endtask

  // Counts and verdict
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, osc} = 0;
    reset = 1;
    oc = '{default: 0};
    {mismatches, compares, src, xtl} = 0;
    ctl = 1;
    void'($urandom(32'h0BC0EC39));
    hp = '{2, 2 + $urandom_range(2), 10, 13};
    repeat (20) @(posedge clk);
    reset <= 0;
    rd(8'h00, 0, 'hFF);
    rd(8'h04, 0, 'hFF);
    rd(8'h08, 1, 'hFF);
    outs();
    $display("test reset done");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_v, 0, "unmapped data");
    chk(e, 1, "unmapped error");
    wr(8'h0C, 32'h7);
    rd(8'h0C, 0, 5);
    $display("test bus done");
    for (int k = 0; k < 7; k++) begin
      for (int h = 0; h < 2; h++) begin
        wr(8'h00, (k << 5) | (h << 3));
        per();
        per();
        chk(p, (2 * hp[h]) << k, "divided period");
      end
    end
    outs();
    wr(8'h00, 'hE0);
    per();
    per();
    chk(p, 2 * hp[2], "slow rc period");
    wr(8'h08, 0);
    outs();
    $display("test divider done");
    wr(8'h08, 5);
    wr(8'h04, 5);
    rd(8'h04, 5, 7);
    poll(n1);
    wr(8'h04, 1);
    rd(8'h04, 3, 7);
    wr(8'h04, 0);
    wr(8'h04, 1);
    poll(n2);
    chk(n2 > n1, 1, "low power start");
    outs();
    wr(8'h00, 'hE4);
    per();
    per();
    chk(p, 2 * hp[3], "crystal period");
    rd(8'h0C, 1, 1);
    wr(8'h04, 5);
    rd(8'h04, 3, 7);
    $display("test crystal done");
    wr(8'h08, 7);
    repeat (300) @(posedge clk);
    {n1, n2} = 0;
    tp = en[6];
    repeat (300) begin
      @(posedge clk);
      n1 += (en[5] !== 1'b0);
      n2 += (en[6] !== tp);
      tp = en[6];
    end
    chk(n1, 0, "halted clock");
    chk(n2 > 0, 1, "timer clock");
    rd(8'h0C, 7, 7);
    wr(8'h08, 5);
    per();
    per();
    chk(p, 2 * hp[3], "after halt");
    wr(8'h00, 0);
    wr(8'h04, 5);
    rd(8'h04, 7, 7);
    outs();
    wr(8'h08, 1);
    outs();
    rd(8'h04, 5, 7);
    $display("test halt done");
    end_sim();
  end
endmodule
`default_nettype wire
